// *** inc/aab_defs.svh ***
`ifndef AAB_DEFS_SVH
`define AAB_DEFS_SVH

// opcode upper-bit patterns
`define AAB_OPC_ADDC 6'h08
`define AAB_OPC_ANDF 6'h05
`define AAB_OPC_ANDL 8'h0B
`define AAB_OPC_BRANCH_ON_CARRY 8'hE2
`define AAB_OPC_CLEAR_FILE_BIT 4'h9

// instruction field positions
`define AAB_D_BIT 9
`define AAB_A_BIT 8
`define AAB_BIT_LSB 9

// status field positions
`define AAB_ST_C 0
`define AAB_ST_DIGIT_CARRY_FLAG 1
`define AAB_ST_Z 2
`define AAB_ST_OVERFLOW_FLAG 3
`define AAB_ST_N 4

// addressing
`define AAB_IDX_MAX 8'h5F
`define AAB_ACC_SPLIT 8'h60
`define AAB_ACC_HI_BANK 4'hF

// reset values
`define AAB_RST_BYTE 8'h00
`define AAB_RST_ADDR 12'h000
`define AAB_RST_INSTR 16'h0000

`endif

// *** inc/aab_pkg.sv ***
`default_nettype none
package aab_pkg;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} aab_phase_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADDC,
    OP_ANDL,
    OP_ANDF,
    OP_BRANCH_ON_CARRY,
    OP_CLEAR_FILE_BIT
  } aab_op_t;

  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } aab_status_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } aab_mem_wr_t;

endpackage
`default_nettype wire

// *** design/aab_exec.sv ***
// Summary of operation
// - add-with-carry sums W, the file byte and carry, and sends the byte to the destination.
// - add-with-carry updates negative, overflow, carry, digit carry and zero.
// - destination bit zero writes W, one writes the addressed file location.
// - the default destination (bit set) writes back to the file register.
// - bank bit zero selects the access bank, one takes the bank number from the bank select.
// - with extended set on, bank bit zero and file address up to 95 use indexed offset mode.
// - AND-register ANDs W with the file byte and writes the selected destination.
// - both ANDs update only negative and zero.
// - branch-on-carry branches only when carry is one, signed 8-bit offset, no flags.
// - a taken branch loads incremented counter plus twice the sign-extended offset.
// - a taken branch takes two cycles, the second a no-op; not taken takes one, no write.
`timescale 1ns/1ns
`default_nettype none
`include "aab_defs.svh"

module aab_exec #(
  parameter int PROGRAM_COUNTER_W = 21,
  parameter int BANK_W = 4
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] instr_i,
  input wire logic ext_set_en_i,
  input wire logic [BANK_W-1:0] bank_select_register_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] work_i,
  input wire aab_pkg::aab_status_t status_i,
  input wire logic [PROGRAM_COUNTER_W-1:0] program_counter_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [1:0] phase_o,
  output logic mem_rd_o,
  output logic [11:0] mem_addr_o,
  output aab_pkg::aab_mem_wr_t mem_wr_o,
  output logic work_we_o,
  output logic [7:0] work_wdata_o,
  output logic status_we_o,
  output aab_pkg::aab_status_t status_o,
  output logic program_counter_we_o,
  output logic [PROGRAM_COUNTER_W-1:0] program_counter_o,
  output logic nop_cycle_o
);
  import aab_pkg::*;

  aab_phase_t phase;
  aab_op_t op;
  logic [15:0] instr;
  logic forced_nop;
  logic [7:0] operand;
  logic [11:0] next_addr;
  logic [7:0] f_field;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] result;
  aab_status_t next_status;
  logic to_file;
  aab_op_t next_op;

  // the address must stand in Q2, so it is formed from the live word
  assign f_field = instr_i[7:0];

  // ----------------------------------------------------------
  // quarter-phase sequencer
  // ----------------------------------------------------------
  // four quarter phases
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase <= PH_Q1;
    else
      phase <= aab_phase_t'(phase + 2'd1);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_o <= 2'd0;
    else
      phase_o <= 2'(phase + 2'd1);
  end

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  always_comb
  begin
    next_op = OP_NONE;
    if (instr_i[15:10] == `AAB_OPC_ADDC)
      next_op = OP_ADDC;
    else if (instr_i[15:10] == `AAB_OPC_ANDF)
      next_op = OP_ANDF;
    else if (instr_i[15:8] == `AAB_OPC_ANDL)
      next_op = OP_ANDL;
    else if (instr_i[15:8] == `AAB_OPC_BRANCH_ON_CARRY)
      next_op = OP_BRANCH_ON_CARRY;
    else if (instr_i[15:12] == `AAB_OPC_CLEAR_FILE_BIT)
      next_op = OP_CLEAR_FILE_BIT;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      op <= OP_NONE;
      instr <= `AAB_RST_INSTR;
    end
    else if (phase == PH_Q1)
    begin
      op <= forced_nop ? OP_NONE : next_op;
      instr <= instr_i;
    end
  end

  // ----------------------------------------------------------
  // operand address
  // ----------------------------------------------------------
  always_comb
  begin
    // bank bit one: bank select register
    if (instr_i[`AAB_A_BIT])
      next_addr = {bank_select_register_i, f_field};
    else if (ext_set_en_i && (f_field <= `AAB_IDX_MAX))
      next_addr = 12'(index_base_i + {4'h0, f_field});
    else if (f_field < `AAB_ACC_SPLIT)
      next_addr = {4'h0, f_field};
    else
      next_addr = {`AAB_ACC_HI_BANK, f_field};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mem_rd_o <= 1'b0;
      mem_addr_o <= `AAB_RST_ADDR;
    end
    else if (phase == PH_Q1)
    begin
      // a flushed cycle must not read
      mem_rd_o <= !forced_nop && ((next_op == OP_ADDC) || (next_op == OP_ANDF)
        || (next_op == OP_CLEAR_FILE_BIT));
      mem_addr_o <= next_addr;
    end
    else if (phase == PH_Q2)
    begin
      mem_rd_o <= 1'b0;
    end
  end

  // operand captured at end of Q2
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      operand <= `AAB_RST_BYTE;
    else if (phase == PH_Q2)
      operand <= (op == OP_ANDL) ? instr[7:0] : mem_rdata_i;
  end

  // ----------------------------------------------------------
  // compute
  // ----------------------------------------------------------
  always_comb
  begin
    sum = 9'(work_i + operand + 8'(status_i.c));
    low_sum = 5'(work_i[3:0] + operand[3:0] + 4'(status_i.c));
    next_status = status_i;
    result = sum[7:0];
    unique case (op)
      OP_ADDC:
      begin
        next_status.c = sum[8];
        next_status.digit_carry_flag = low_sum[4];
        next_status.overflow_flag = (work_i[7] == operand[7]) && (sum[7] != work_i[7]);
      end
      OP_ANDL, OP_ANDF:
        result = work_i & operand;
      OP_CLEAR_FILE_BIT:
      begin
        result = operand;
        result[instr[`AAB_BIT_LSB +: 3]] = 1'b0;
      end
      OP_NONE, OP_BRANCH_ON_CARRY:
        result = sum[7:0];
    endcase
    // AND ops touch only N and Z
    next_status.n = result[7];
    next_status.z = (result == 8'h00);
    // set destination bit writes back to file
    to_file = instr[`AAB_D_BIT] || (op == OP_CLEAR_FILE_BIT);
  end

  // ----------------------------------------------------------
  // write back
  // ----------------------------------------------------------
  // write strobes stand in Q4
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mem_wr_o <= '0;
      work_we_o <= 1'b0;
      work_wdata_o <= `AAB_RST_BYTE;
    end
    else if (phase == PH_Q3)
    begin
      mem_wr_o.we <= ((op == OP_ADDC) || (op == OP_ANDF)) && to_file
        || (op == OP_CLEAR_FILE_BIT);
      mem_wr_o.addr <= mem_addr_o;
      mem_wr_o.wdata <= result;
      // literal AND always lands in W
      work_we_o <= ((op == OP_ADDC) || (op == OP_ANDF)) && !to_file
        || (op == OP_ANDL);
      work_wdata_o <= result;
    end
    else if (phase == PH_Q4)
    begin
      mem_wr_o.we <= 1'b0;
      work_we_o <= 1'b0;
    end
  end

  // status write: branch and bit-clear leave flags alone
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      status_we_o <= 1'b0;
      status_o <= '0;
    end
    else if (phase == PH_Q3)
    begin
      status_we_o <= (op == OP_ADDC) || (op == OP_ANDL) || (op == OP_ANDF);
      status_o <= next_status;
    end
    else if (phase == PH_Q4)
    begin
      status_we_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // relative branch
  // ----------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      program_counter_we_o <= 1'b0;
      program_counter_o <= '0;
    end
    else if (phase == PH_Q3)
    begin
      program_counter_we_o <= (op == OP_BRANCH_ON_CARRY) && status_i.c;
      program_counter_o <= PROGRAM_COUNTER_W'(program_counter_i
        + {{(PROGRAM_COUNTER_W-9){instr[7]}}, instr[7:0], 1'b0});
    end
    else if (phase == PH_Q4)
    begin
      program_counter_we_o <= 1'b0;
    end
  end

  // the flush is held for exactly one instruction cycle so the
  // already fetched word is never executed
  // second cycle is a no-op
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      forced_nop <= 1'b0;
      nop_cycle_o <= 1'b0;
    end
    else if (phase == PH_Q4)
    begin
      // follows the taken strobe so both agree on one carry sample
      forced_nop <= program_counter_we_o;
      nop_cycle_o <= program_counter_we_o;
    end
  end

endmodule // aab_exec

`default_nettype wire

// *** dv/aab_exec_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module aab_exec_properties (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] phase_o,
  input wire logic mem_rd_o,
  input wire logic [11:0] mem_addr_o,
  input wire aab_pkg::aab_mem_wr_t mem_wr_o,
  input wire logic work_we_o,
  input wire logic status_we_o,
  input wire logic program_counter_we_o,
  input wire logic nop_cycle_o
);
  import aab_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rd;
    mem_rd_o |-> phase_o == 2'h1;
  endproperty
  a_rd: assert property (p_rd) else $error("read outside q2");
  property p_we;
    (mem_wr_o.we || work_we_o || status_we_o) |-> phase_o == 2'h3;
  endproperty
  a_we: assert property (p_we) else $error("write outside q4");
  property p_ph;
    phase_o == 2'h3 |=> phase_o == 2'h0;
  endproperty
  a_ph: assert property (p_ph) else $error("phase wrap");
  property p_dst;
    mem_rd_o |-> ##2 (work_we_o || (mem_wr_o.we && mem_wr_o.addr == $past(mem_addr_o, 2)));
  endproperty
  a_dst: assert property (p_dst) else $error("no destination write");
  property p_hold;
    mem_rd_o |=> $stable(mem_addr_o) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_pc;
    program_counter_we_o |-> !status_we_o && !$past(mem_rd_o, 2);
  endproperty
  a_pc: assert property (p_pc) else $error("branch touched flags");
  property p_nop;
    program_counter_we_o |=> nop_cycle_o [*4] ##1 !nop_cycle_o;
  endproperty
  a_nop: assert property (p_nop) else $error("flush cycle length");
  property p_quiet;
    nop_cycle_o |-> !(mem_rd_o || mem_wr_o.we || work_we_o || status_we_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("strobe in flush");
endmodule // aab_exec_properties
`default_nettype wire

// *** dv/aab_exec_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module aab_exec_tb;
  import aab_pkg::*;
  logic mclk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic ext_set_en_i = 1'h0;
  logic next_ext = 1'h0;
  logic [15:0] instr_i = 16'h0000;
  logic [3:0] bank_select_register_i = 4'h0;
  logic [3:0] next_bank = 4'h0;
  logic [11:0] index_base_i = 12'h000;
  logic [11:0] next_base = 12'h000;
  logic [7:0] work_i = 8'h00;
  logic [7:0] mem_rdata_i = 8'h00;
  aab_status_t status_i = 5'h00;
  logic [20:0] program_counter_i = 21'h0_0000;
  logic [20:0] next_program_counter = 21'h0_0100;
  logic [1:0] phase_o;
  logic mem_rd_o;
  logic [11:0] mem_addr_o;
  aab_mem_wr_t mem_wr_o;
  logic work_we_o;
  logic [7:0] work_wdata_o;
  logic status_we_o;
  aab_status_t status_o;
  logic program_counter_we_o;
  logic [20:0] program_counter_o;
  logic nop_cycle_o;
  logic rd_seen;
  logic [11:0] rd_a;
  int n_fail = 0;
  int total_checks = 0;

  always #5 mclk_i = ~mclk_i;

  aab_exec u_dut (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .instr_i(instr_i),
    .ext_set_en_i(ext_set_en_i),
    .bank_select_register_i(bank_select_register_i),
    .index_base_i(index_base_i),
    .work_i(work_i),
    .status_i(status_i),
    .program_counter_i(program_counter_i),
    .mem_rdata_i(mem_rdata_i),
    .phase_o(phase_o),
    .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o),
    .mem_wr_o(mem_wr_o),
    .work_we_o(work_we_o),
    .work_wdata_o(work_wdata_o),
    .status_we_o(status_we_o),
    .status_o(status_o),
    .program_counter_we_o(program_counter_we_o),
    .program_counter_o(program_counter_o),
    .nop_cycle_o(nop_cycle_o)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // issues at q1 and returns at q4, so calls run back to back
  task automatic exec(input logic [15:0] ins, input logic [7:0] w, input logic [7:0] d,
    input logic [4:0] st);
    while (phase_o !== 2'h3)
      @(negedge mclk_i);
    @(posedge mclk_i);
    instr_i <= ins;
    work_i <= w;
    mem_rdata_i <= d;
    status_i <= st;
    ext_set_en_i <= next_ext;
    bank_select_register_i <= next_bank;
    index_base_i <= next_base;
    program_counter_i <= next_program_counter;
    rd_seen = 1'h0;
    repeat (4)
    begin
      @(negedge mclk_i);
      if (mem_rd_o === 1'h1)
      begin
        rd_seen = 1'h1;
        rd_a = mem_addr_o;
      end
    end
  endtask

  task automatic t_addc;
    next_bank = 4'h3;
    exec(16'h2125, 8'h4D, 8'h02, 5'h01);
    chk("ra", 12'h325, rd_a);
    chk("ww", 1'h1, work_we_o);
    chk("fw", 1'h0, mem_wr_o.we);
    chk("wd", 8'h50, work_wdata_o);
    chk("st", 5'h02, status_o);
    exec(16'h2270, 8'h80, 8'h80, 5'h00);
    chk("fw", 1'h1, mem_wr_o.we);
    chk("fa", 12'hF70, mem_wr_o.addr);
    chk("fd", 8'h00, mem_wr_o.wdata);
    chk("st", 5'h0D, status_o);
    exec(16'h2015, 8'h7F, 8'h01, 5'h00);
    chk("ra", 12'h015, rd_a);
    chk("wd", 8'h80, work_wdata_o);
    chk("st", 5'h1A, status_o);
    $display("t_addc done");
  endtask

  task automatic t_andf;
    next_ext = 1'h1;
    next_base = 12'h123;
    exec(16'h145F, 8'h17, 8'hC2, 5'h1F);
    chk("ra", 12'h182, rd_a);
    chk("wd", 8'h02, work_wdata_o);
    chk("st", 5'h0B, status_o);
    exec(16'h1460, 8'h80, 8'hF0, 5'h00);
    chk("ra", 12'hF60, rd_a);
    chk("wd", 8'h80, work_wdata_o);
    chk("st", 5'h10, status_o);
    next_ext = 1'h0;
    $display("t_andf done");
  endtask

  task automatic t_andl;
    exec(16'h0B5F, 8'hA3, 8'h00, 5'h1F);
    chk("rd", 1'h0, rd_seen);
    chk("wd", 8'h03, work_wdata_o);
    chk("st", 5'h0B, status_o);
    exec(16'h0B00, 8'hFF, 8'h00, 5'h00);
    chk("st", 5'h04, status_o);
    $display("t_andl done");
  endtask

  task automatic t_branch;
    exec(16'hE205, 8'h00, 8'h00, 5'h01);
    chk("pw", 1'h1, program_counter_we_o);
    chk("target", 21'h0_010A, program_counter_o);
    chk("sw", 1'h0, status_we_o);
    @(negedge mclk_i);
    chk("nop", 1'h1, nop_cycle_o);
    next_program_counter = 21'h0_0200;
    exec(16'hE280, 8'h00, 8'h00, 5'h01);
    chk("target", 21'h0_0100, program_counter_o);
    @(negedge mclk_i);
    chk("nop", 1'h1, nop_cycle_o);
    // let the flushed cycle pass so the next word is really decoded
    repeat (3) @(negedge mclk_i);
    exec(16'hE205, 8'h00, 8'h00, 5'h1E);
    chk("pw", 1'h0, program_counter_we_o);
    chk("sw", 1'h0, status_we_o);
    @(negedge mclk_i);
    chk("nop", 1'h0, nop_cycle_o);
    $display("t_branch done");
  endtask

  task automatic t_bitclear;
    next_bank = 4'h2;
    exec(16'h9F10, 8'hFF, 8'hC7, 5'h1F);
    chk("fw", 1'h1, mem_wr_o.we);
    chk("fa", 12'h210, mem_wr_o.addr);
    chk("fd", 8'h47, mem_wr_o.wdata);
    chk("sw", 1'h0, status_we_o);
    exec(16'h9110, 8'hFF, 8'hFF, 5'h00);
    chk("fd", 8'hFE, mem_wr_o.wdata);
    chk("ww", 1'h0, work_we_o);
    $display("t_bitclear done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    @(negedge mclk_i);
    t_addc();
    t_andf();
    t_andl();
    t_branch();
    t_bitclear();
    finish_test();
  end

  // a dozen instructions need well under 1 us
  initial
  begin
    #20000;
    n_fail++;
    finish_test();
  end
endmodule // aab_exec_tb

bind aab_exec aab_exec_properties u_props (
  .mclk_i(mclk_i),
  .reset_n_i(reset_n_i),
  .phase_o(phase_o),
  .mem_rd_o(mem_rd_o),
  .mem_addr_o(mem_addr_o),
  .mem_wr_o(mem_wr_o),
  .work_we_o(work_we_o),
  .status_we_o(status_we_o),
  .program_counter_we_o(program_counter_we_o),
  .nop_cycle_o(nop_cycle_o)
);
`default_nettype wire
